// *** rtl/lane_alarm_enable_masks.sv ***
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module lane_alarm_enable_masks #(
    parameter int unsigned NUM_LANES = 16
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [lane_mask_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [lane_mask_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Monitored conditions, one entry per lane
    input wire lane_mask_pkg::lane_cond_t [15:0] lane_cond,
    // Alarm outputs
    output logic summary_alarm,
    output logic irq
);

    lane_mask_pkg::bank_state_t st_r;
    lane_mask_pkg::bank_state_t st_nxt;
    lane_mask_pkg::lane_cond_t [15:0] lat_w;
    lane_mask_pkg::lane_cond_t [15:0] fresh_w;
    logic [15:0] clr1_w;
    logic [15:0] clr2_w;
    logic [15:0] clrf_w;
    logic [15:0] wr_idx;
    logic [15:0] rd_idx;
    lane_mask_pkg::grp_t wr_grp;
    lane_mask_pkg::grp_t rd_grp;
    logic [3:0] wr_lane;
    logic [3:0] rd_lane;
    logic wr_lane_ok;
    logic rd_lane_ok;
    logic wr_go;
    logic ar_go;
    logic [15:0] smask;
    logic [15:0] lane_ev;
    logic alarm_any;

    function automatic lane_mask_pkg::grp_t decode(input logic [15:0] idx);
        if (idx[15:4] == lane_mask_pkg::EN1_BASE[15:4]) begin
            return lane_mask_pkg::GRP_EN1;
        end
        if (idx[15:4] == lane_mask_pkg::EN2_BASE[15:4]) begin
            return lane_mask_pkg::GRP_EN2;
        end
        if (idx[15:4] == lane_mask_pkg::ENF_BASE[15:4]) begin
            return lane_mask_pkg::GRP_ENF;
        end
        if (idx[15:4] == lane_mask_pkg::LAT1_BASE[15:4]) begin
            return lane_mask_pkg::GRP_LAT1;
        end
        if (idx[15:4] == lane_mask_pkg::LAT2_BASE[15:4]) begin
            return lane_mask_pkg::GRP_LAT2;
        end
        if (idx[15:4] == lane_mask_pkg::LATF_BASE[15:4]) begin
            return lane_mask_pkg::GRP_LATF;
        end
        if (idx[15:4] == lane_mask_pkg::CTL_BASE[15:4]) begin
            return lane_mask_pkg::GRP_CTL;
        end
        return lane_mask_pkg::GRP_NONE;
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] val,
                                          input logic [15:0] msk);
        return (old & ~msk) | (val & msk);
    endfunction

    // One latch block per implemented lane
    for (genvar n = 0; n < 16; n++) begin : g_lane
        if (n < NUM_LANES) begin : g_on
            lane_condition_latch u_latch (
                .aclk(aclk),
                .aresetn(aresetn),
                .cond(lane_cond[n]),
                .clr1(clr1_w[n]),
                .clr2(clr2_w[n]),
                .clrf(clrf_w[n]),
                .latched(lat_w[n]),
                .fresh(fresh_w[n])
            );
        end else begin : g_off
            assign lat_w[n] = '0;
            assign fresh_w[n] = '0;
        end
    end

    assign wr_idx = st_r.awaddr[lane_mask_pkg::ADDR_W-1:2];
    assign rd_idx = araddr[lane_mask_pkg::ADDR_W-1:2];
    assign wr_grp = decode(wr_idx);
    assign rd_grp = decode(rd_idx);
    assign wr_lane = wr_idx[3:0];
    assign rd_lane = rd_idx[3:0];
    assign wr_lane_ok = {1'b0, wr_lane} < 5'(NUM_LANES);
    assign rd_lane_ok = {1'b0, rd_lane} < 5'(NUM_LANES);
    assign wr_go = !st_r.aw_rdy && !st_r.w_rdy && !st_r.bvalid;
    assign ar_go = arvalid && st_r.ar_rdy;
    assign smask = {{8{st_r.wstrb[1]}}, {8{st_r.wstrb[0]}}};

    // Enabled latches per lane, for summary and events
    always_comb begin
        lane_ev = '0;
        alarm_any = 1'b0;
        for (int i = 0; i < 16; i++) begin
            lane_ev[i] = |(fresh_w[i].set1 & st_r.en1[i])
                       | |(fresh_w[i].set2 & st_r.en2[i][3:0])
                       | |(fresh_w[i].fault & st_r.enf[i]);
            alarm_any = alarm_any
                      | (|(lat_w[i].set1 & st_r.en1[i]))
                      | (|(lat_w[i].set2 & st_r.en2[i][3:0]))
                      | (|(lat_w[i].fault & st_r.enf[i]));
        end
    end

    always_comb begin
        st_nxt = st_r;
        clr1_w = '0;
        clr2_w = '0;
        clrf_w = '0;
        if (awvalid && st_r.aw_rdy) begin
            st_nxt.awaddr = awaddr;
            st_nxt.aw_rdy = 1'b0;
        end
        if (wvalid && st_r.w_rdy) begin
            st_nxt.wdata = wdata;
            st_nxt.wstrb = wstrb;
            st_nxt.w_rdy = 1'b0;
        end
        if (st_r.bvalid && bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (wr_go) begin
            st_nxt.bvalid = 1'b1;
            st_nxt.aw_rdy = 1'b1;
            st_nxt.w_rdy = 1'b1;
            st_nxt.bresp = lane_mask_pkg::RESP_OKAY;
            unique case (wr_grp)
                lane_mask_pkg::GRP_EN1: begin
                    if (wr_lane_ok) begin
                        st_nxt.en1[wr_lane] = merge(st_r.en1[wr_lane],
                            st_r.wdata[15:0],
                            smask & lane_mask_pkg::DEF1);
                    end
                end
                lane_mask_pkg::GRP_EN2: begin
                    if (wr_lane_ok) begin
                        st_nxt.en2[wr_lane] = merge(st_r.en2[wr_lane],
                            st_r.wdata[15:0],
                            smask & {12'h000, lane_mask_pkg::DEF2});
                    end
                end
                lane_mask_pkg::GRP_ENF: begin
                    if (wr_lane_ok) begin
                        st_nxt.enf[wr_lane] = merge(st_r.enf[wr_lane],
                            st_r.wdata[15:0],
                            smask & lane_mask_pkg::DEFF);
                    end
                end
                lane_mask_pkg::GRP_LAT1, lane_mask_pkg::GRP_LAT2,
                lane_mask_pkg::GRP_LATF: begin
                    st_nxt.bresp = lane_mask_pkg::RESP_OKAY;
                end
                lane_mask_pkg::GRP_CTL: begin
                    if (wr_idx == lane_mask_pkg::IRQ_STAT_IDX) begin
                        st_nxt.irq_stat = st_r.irq_stat
                                        & ~(st_r.wdata[15:0] & smask);
                    end
                    if (wr_idx == lane_mask_pkg::IRQ_MASK_IDX) begin
                        st_nxt.irq_mask = merge(st_r.irq_mask,
                            st_r.wdata[15:0], smask);
                    end
                end
                lane_mask_pkg::GRP_NONE: begin
                    st_nxt.bresp = lane_mask_pkg::RESP_SLVERR;
                end
            endcase
        end
        // New events win over a clear in the same cycle
        st_nxt.irq_stat = st_nxt.irq_stat | lane_ev;

        if (st_r.rvalid && rready) begin
            st_nxt.rvalid = 1'b0;
            st_nxt.ar_rdy = 1'b1;
        end
        if (ar_go) begin
            st_nxt.ar_rdy = 1'b0;
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = lane_mask_pkg::RESP_OKAY;
            st_nxt.rdata = '0;
            unique case (rd_grp)
                lane_mask_pkg::GRP_EN1: begin
                    st_nxt.rdata[15:0] = st_r.en1[rd_lane];
                end
                lane_mask_pkg::GRP_EN2: begin
                    st_nxt.rdata[15:0] = st_r.en2[rd_lane];
                end
                lane_mask_pkg::GRP_ENF: begin
                    st_nxt.rdata[15:0] = st_r.enf[rd_lane];
                end
                lane_mask_pkg::GRP_LAT1: begin
                    st_nxt.rdata[15:0] = lat_w[rd_lane].set1;
                    clr1_w[rd_lane] = rd_lane_ok;
                end
                lane_mask_pkg::GRP_LAT2: begin
                    st_nxt.rdata[3:0] = lat_w[rd_lane].set2;
                    clr2_w[rd_lane] = rd_lane_ok;
                end
                lane_mask_pkg::GRP_LATF: begin
                    st_nxt.rdata[15:0] = lat_w[rd_lane].fault;
                    clrf_w[rd_lane] = rd_lane_ok;
                end
                lane_mask_pkg::GRP_CTL: begin
                    if (rd_idx == lane_mask_pkg::IRQ_STAT_IDX) begin
                        st_nxt.rdata[15:0] = st_r.irq_stat;
                    end
                    if (rd_idx == lane_mask_pkg::IRQ_MASK_IDX) begin
                        st_nxt.rdata[15:0] = st_r.irq_mask;
                    end
                    if (rd_idx == lane_mask_pkg::LANE_CNT_IDX) begin
                        st_nxt.rdata[4:0] = 5'(NUM_LANES);
                    end
                end
                lane_mask_pkg::GRP_NONE: begin
                    st_nxt.rresp = lane_mask_pkg::RESP_SLVERR;
                end
            endcase
        end
        st_nxt.irq = |(st_r.irq_stat & st_r.irq_mask);
        st_nxt.summary = alarm_any;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.aw_rdy <= 1'b1;
            st_r.w_rdy <= 1'b1;
            st_r.ar_rdy <= 1'b1;
            st_r.en1 <= {16{lane_mask_pkg::EN1_RST}};
            st_r.en2 <= {16{lane_mask_pkg::EN2_RST}};
            st_r.enf <= {16{lane_mask_pkg::ENF_RST}};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign awready = st_r.aw_rdy;
    assign wready = st_r.w_rdy;
    assign bvalid = st_r.bvalid;
    assign bresp = st_r.bresp;
    assign arready = st_r.ar_rdy;
    assign rvalid = st_r.rvalid;
    assign rdata = st_r.rdata;
    assign rresp = st_r.rresp;
    assign irq = st_r.irq;
    assign summary_alarm = st_r.summary;

    AST_RESET_VALUES: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !$past(aresetn) |-> st_r.en1[0] == lane_mask_pkg::EN1_RST
            && st_r.en2[0] == lane_mask_pkg::EN2_RST
            && st_r.enf[0] == lane_mask_pkg::ENF_RST)
        else $error("enable registers left reset with wrong value");

    AST_EN1_WRITE: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (wr_go && wr_grp == lane_mask_pkg::GRP_EN1 && wr_lane_ok
            && st_r.wstrb[1:0] == 2'h3)
        |=> st_r.bvalid
            && st_r.en1[$past(wr_lane)] == $past(st_r.wdata[15:0]))
        else $error("first set enable write not stored");

    AST_EN2_RESERVED: assert property (
        @(posedge aclk) disable iff (!aresetn)
        st_r.en2[3][15:4] == 12'hFFF)
        else $error("second set reserved bits changed");

    AST_FAULT_RESERVED: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (st_r.enf[5] & ~lane_mask_pkg::DEFF)
            == (lane_mask_pkg::ENF_RST & ~lane_mask_pkg::DEFF))
        else $error("fault reserved bits changed");

    AST_READ_ENABLE: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (ar_go && rd_grp == lane_mask_pkg::GRP_EN1)
        |=> st_r.rvalid
            && st_r.rdata == {16'h0000, $past(st_r.en1[rd_lane])})
        else $error("enable read returned wrong data");

    AST_LATCH_READ: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (ar_go && rd_grp == lane_mask_pkg::GRP_LAT1 && rd_lane_ok)
        |=> st_r.rdata[15:0] == $past(lat_w[rd_lane].set1)
            && lat_w[$past(rd_lane)].set1 == fresh_w[$past(rd_lane)].set1)
        else $error("latch read data or clear wrong");

    AST_SUMMARY: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (|(lat_w[2].set1 & st_r.en1[2])) |=> summary_alarm)
        else $error("summary alarm does not follow enabled latches");

    AST_UNMAPPED_WRITE: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (wr_go && wr_grp == lane_mask_pkg::GRP_NONE)
        |=> st_r.bvalid && st_r.bresp == lane_mask_pkg::RESP_SLVERR
            && st_r.en1 == $past(st_r.en1) && st_r.enf == $past(st_r.enf))
        else $error("unmapped write altered state or bad response");

    AST_IRQ_LEVEL: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (st_r.irq_stat == 16'h0000) [*2] |=> !irq)
        else $error("interrupt high with no status bit");

    AST_LANE_LIMIT: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (ar_go && rd_grp == lane_mask_pkg::GRP_CTL
            && rd_idx == lane_mask_pkg::LANE_CNT_IDX)
        |=> st_r.rdata == 32'(NUM_LANES))
        else $error("lane count register wrong");

endmodule
`default_nettype wire

// *** rtl/lane_condition_latch.sv ***
`timescale 1ns/1ps
`default_nettype none
module lane_condition_latch (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Raw conditions from monitors
    input wire lane_mask_pkg::lane_cond_t cond,
    // Read-clear pulses per group
    input wire logic clr1,
    input wire logic clr2,
    input wire logic clrf,
    // Latch state
    output lane_mask_pkg::lane_cond_t latched,
    output lane_mask_pkg::lane_cond_t fresh
);

    lane_mask_pkg::latch_state_t st_r;
    lane_mask_pkg::latch_state_t st_nxt;
    lane_mask_pkg::lane_cond_t set_w;
    lane_mask_pkg::lane_cond_t clr_w;

    always_comb begin
        st_nxt = st_r;
        st_nxt.sync1 = cond;
        st_nxt.sync2 = st_r.sync1;
        set_w = st_r.sync2 & {lane_mask_pkg::DEF1, lane_mask_pkg::DEF2,
                              lane_mask_pkg::DEFF};
        clr_w = {{16{clr1}}, {4{clr2}}, {16{clrf}}};
        // Set wins over a clear in the same cycle
        st_nxt.latched = (st_r.latched & ~clr_w) | set_w;
        st_nxt.fresh = set_w & ~(st_r.latched & ~clr_w);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign latched = st_r.latched;
    assign fresh = st_r.fresh;

endmodule
`default_nettype wire

// *** rtl/lane_mask_pkg.sv ***
package lane_mask_pkg;

    localparam int unsigned ADDR_W = 18;
    localparam int unsigned MAX_LANES = 16;

    // Register word indices; byte address is four times the index
    localparam logic [15:0] EN1_BASE = 16'hB1E0;
    localparam logic [15:0] EN2_BASE = 16'hB1F0;
    localparam logic [15:0] ENF_BASE = 16'hB200;
    localparam logic [15:0] LAT1_BASE = 16'hB1B0;
    localparam logic [15:0] LAT2_BASE = 16'hB1C0;
    localparam logic [15:0] LATF_BASE = 16'hB1D0;
    localparam logic [15:0] CTL_BASE = 16'hB100;
    localparam logic [15:0] IRQ_STAT_IDX = 16'hB100;
    localparam logic [15:0] IRQ_MASK_IDX = 16'hB101;
    localparam logic [15:0] LANE_CNT_IDX = 16'hB102;

    // Reset values
    localparam logic [15:0] EN1_RST = 16'hFFFF;
    localparam logic [15:0] EN2_RST = 16'hFFFF;
    localparam logic [15:0] ENF_RST = 16'hE0DC;

    // Field positions, four bits each for the alarm fields and one bit for cooler and unlock: high alarm down to low alarm
    localparam int unsigned BIAS_LSB = 12;
    localparam int unsigned TXPWR_LSB = 8;
    localparam int unsigned TEMP_LSB = 4;
    localparam int unsigned RXPWR_LSB = 0;
    localparam int unsigned MOD_LSB = 0;
    localparam int unsigned COOLER_BIT = 15;
    localparam int unsigned UNLOCK_BIT = 14;

    // Defined (writable) bits of each group
    localparam logic [15:0] DEF1 = 16'hFFFF;
    localparam logic [3:0] DEF2 = 4'hF;
    localparam logic [15:0] DEFF = 16'hC092;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        GRP_NONE = 3'b000,
        GRP_EN1 = 3'b001,
        GRP_EN2 = 3'b010,
        GRP_ENF = 3'b011,
        GRP_LAT1 = 3'b100,
        GRP_LAT2 = 3'b101,
        GRP_LATF = 3'b110,
        GRP_CTL = 3'b111
    } grp_t;

    // Conditions of one lane, and the latches in the same layout
    typedef struct packed {
        logic [15:0] set1;
        logic [3:0] set2;
        logic [15:0] fault;
    } lane_cond_t;

    typedef struct packed {
        lane_cond_t sync1;
        lane_cond_t sync2;
        lane_cond_t latched;
        lane_cond_t fresh;
    } latch_state_t;

    typedef struct packed {
        logic aw_rdy;
        logic w_rdy;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [15:0][15:0] en1;
        logic [15:0][15:0] en2;
        logic [15:0][15:0] enf;
        logic [15:0] irq_stat;
        logic [15:0] irq_mask;
        logic irq;
        logic summary;
    } bank_state_t;

endpackage

// *** test/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock
    input wire logic aclk,
    // Write channels
    output var logic [lane_mask_pkg::ADDR_W-1:0] awaddr,
    output var logic awvalid,
    input wire logic awready,
    output var logic [31:0] wdata,
    output var logic [3:0] wstrb,
    output var logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output var logic bready,
    // Read channels
    output var logic [lane_mask_pkg::ADDR_W-1:0] araddr,
    output var logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output var logic rready
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end

    // Released addresses and write data are inverted so stale values are never trusted; wstrb stays at 4'h3
    task automatic write_reg(input logic [15:0] idx, input logic [15:0] val,
                             output logic [1:0] resp);
        @(posedge aclk);
        awaddr <= {idx, 2'h0};
        wdata <= {16'h0000, val};
        wstrb <= 4'h3;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~awaddr;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~wdata;
            end
        end while (!(bvalid && bready));
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic read_reg(input logic [15:0] idx, output logic [31:0] data,
                            output logic [1:0] resp);
        @(posedge aclk);
        araddr <= {idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~araddr;
            end
        end while (!(rvalid && rready));
        data = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int LANES = 4;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [lane_mask_pkg::ADDR_W-1:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, summary_alarm, irq;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    lane_mask_pkg::lane_cond_t [15:0] lane_cond = '0;
    int num_errors = 0;
    int samples_checked = 0;

    always #25 aclk = ~aclk;

    lane_alarm_enable_masks #(.NUM_LANES(LANES)) lane_alarm_enable_masks_i (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .lane_cond(lane_cond),
        .summary_alarm(summary_alarm), .irq(irq));

    host_model host_model_i (
        .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] idx, input logic [15:0] val);
        logic [1:0] resp;
        host_model_i.write_reg(idx, val, resp);
        check("bresp", {30'h0, resp}, {30'h0, lane_mask_pkg::RESP_OKAY});
    endtask

    task automatic rd(input logic [15:0] idx, input logic [15:0] exp,
                      input string what);
        logic [31:0] data;
        logic [1:0] resp;
        host_model_i.read_reg(idx, data, resp);
        check(what, data, {16'h0000, exp});
        check("rresp", {30'h0, resp}, {30'h0, lane_mask_pkg::RESP_OKAY});
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask

    task automatic setc(input int lane, input lane_mask_pkg::lane_cond_t c);
        @(posedge aclk);
        lane_cond[lane] <= c;
    endtask

    task automatic test_reset;
        rd(lane_mask_pkg::EN1_BASE, 16'hFFFF, "set1 lane0");
        rd(lane_mask_pkg::EN1_BASE + 16'h000F, 16'hFFFF, "set1 lane15");
        rd(lane_mask_pkg::EN2_BASE + 16'h0003, 16'hFFFF, "set2 rst");
        rd(lane_mask_pkg::ENF_BASE + 16'h0001, 16'hE0DC, "fault rst");
        rd(lane_mask_pkg::LANE_CNT_IDX, LANES[15:0], "lane count");
        $display("test reset done");
    endtask

    task automatic test_regs;
        wr(lane_mask_pkg::EN1_BASE + 16'h0003, 16'h1234);
        rd(lane_mask_pkg::EN1_BASE + 16'h0003, 16'h1234, "set1 rw");
        wr(lane_mask_pkg::EN1_BASE + 16'h0005, 16'h0000);
        rd(lane_mask_pkg::EN1_BASE + 16'h0005, 16'hFFFF, "lane5");
        wr(lane_mask_pkg::EN2_BASE, 16'h0000);
        rd(lane_mask_pkg::EN2_BASE, 16'hFFF0, "set2 rsvd");
        setc(0, {16'h0000, 4'hA, 16'h0000});
        settle(6);
        check("set2 masked", {31'h0, summary_alarm}, 32'h0);
        setc(0, '0);
        settle(3);
        rd(lane_mask_pkg::LAT2_BASE, 16'h000A, "set2 latch");
        wr(lane_mask_pkg::EN2_BASE, 16'hFFFF);
        wr(lane_mask_pkg::ENF_BASE + 16'h0001, 16'h0000);
        rd(lane_mask_pkg::ENF_BASE + 16'h0001, 16'h204C, "fault 0");
        wr(lane_mask_pkg::ENF_BASE + 16'h0001, 16'hFFFF);
        rd(lane_mask_pkg::ENF_BASE + 16'h0001, 16'hE0DE, "fault 1");
        wr(lane_mask_pkg::ENF_BASE + 16'h0001, 16'h4000);
        setc(1, {16'h0000, 4'h0, 16'h8000});
        settle(6);
        check("cooler masked", {31'h0, summary_alarm}, 32'h0);
        setc(1, {16'h0000, 4'h0, 16'hC000});
        settle(6);
        check("unlock on", {31'h0, summary_alarm}, 32'h1);
        setc(1, '0);
        settle(3);
        rd(lane_mask_pkg::LATF_BASE + 16'h0001, 16'hC000, "fault latch");
        $display("test regs done");
    endtask

    task automatic test_fields;
        logic [15:0] own;
        logic [15:0] other;
        for (int f = 0; f < 4; f++) begin
            own = 16'h000F << (4 * f);
            other = 16'h000F << (4 * ((f + 1) % 4));
            wr(lane_mask_pkg::EN1_BASE + 16'h0002, own);
            setc(2, {other, 4'h0, 16'h0000});
            settle(6);
            check("field off", {31'h0, summary_alarm}, 32'h0);
            setc(2, {own | other, 4'h0, 16'h0000});
            settle(6);
            check("field on", {31'h0, summary_alarm}, 32'h1);
            setc(2, '0);
            settle(3);
            rd(lane_mask_pkg::LAT1_BASE + 16'h0002, own | other, "latch");
            rd(lane_mask_pkg::LAT1_BASE + 16'h0002, 16'h0000, "cleared");
            settle(2);
            check("idle", {31'h0, summary_alarm}, 32'h0);
        end
        wr(lane_mask_pkg::EN1_BASE + 16'h0002, 16'hFFFF);
        $display("test fields done");
    endtask

    task automatic test_irq;
        wr(lane_mask_pkg::IRQ_STAT_IDX, 16'hFFFF);
        setc(3, {16'h0004, 4'h0, 16'h0000});
        settle(6);
        check("irq masked", {31'h0, irq}, 32'h0);
        rd(lane_mask_pkg::IRQ_STAT_IDX, 16'h0008, "irq stat");
        wr(lane_mask_pkg::IRQ_MASK_IDX, 16'h0008);
        settle(2);
        check("irq on", {31'h0, irq}, 32'h1);
        setc(3, '0);
        settle(3);
        rd(lane_mask_pkg::LAT1_BASE + 16'h0003, 16'h0004, "lane3 latch");
        wr(lane_mask_pkg::IRQ_STAT_IDX, 16'h0008);
        settle(2);
        check("irq off", {31'h0, irq}, 32'h0);
        rd(lane_mask_pkg::IRQ_STAT_IDX, 16'h0000, "stat clr");
        $display("test irq done");
    endtask

    task automatic test_unmapped;
        logic [31:0] data;
        logic [1:0] resp;
        host_model_i.write_reg(16'h0000, 16'h5555, resp);
        check("unmapped bresp", {30'h0, resp}, 32'h2);
        host_model_i.read_reg(16'h0000, data, resp);
        check("unmapped rresp", {30'h0, resp}, 32'h2);
        check("unmapped rdata", data, 32'h0);
        $display("test unmapped done");
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        test_reset;
        test_regs;
        test_fields;
        test_irq;
        test_unmapped;
        final_report;
    end

    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        final_report;
    end
endmodule
`default_nettype wire
